// file: rsq_pkg.sv
// Package for the reset sequencer and serial clock select block.
// Assumes one system clock at 200 MHz; no software-visible registers.
package rsq_pkg;
  localparam logic [19:0] RSQ_RESTART_ADDR   = 20'hFFFF0;
  localparam int          RSQ_SYNC_STAGES    = 2;
  localparam int          RSQ_OUT_HOLD_CYC   = 2;
  localparam int          RSQ_BUS_START_CYC  = 5;
  localparam int          RSQ_FETCH_CYC      = 7;
  localparam int          RSQ_WDOG_EXIT_CYC  = 65536;
  localparam int          RSQ_MIN_ASSERT_MS  = 1;
  localparam int          RSQ_CLK_MHZ        = 200;
  localparam int          RSQ_MIN_ASSERT_CYC = RSQ_MIN_ASSERT_MS * 1000 * RSQ_CLK_MHZ;
  localparam int          RSQ_STABLE_CYC     = 5;
  localparam logic [4:0]  RSQ_CNT_ZERO       = 5'h00;

  typedef enum logic [1:0] {
    RSQ_ST_RUN  = 2'b00,
    RSQ_ST_EXT  = 2'b01,
    RSQ_ST_WDOG = 2'b10,
    RSQ_ST_EXIT = 2'b11
  } rsq_state_type;

  typedef struct packed {
    logic        bus_enable;
    logic        fetch_enable;
    logic [19:0] restart_addr;
  } rsq_cpu_ctl_type;
endpackage

// file: rsq_sync.sv
// Reset synchronizer: asynchronous assert, synchronous release.
// Assumes i_rst_n may change at any time relative to i_clk.
`timescale 1ns/1ps
module rsq_sync
  import rsq_pkg::*;
#(
  parameter int STAGES = RSQ_SYNC_STAGES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  output logic      o_rst_n
);
  initial begin
    if (STAGES < 2) $error("rsq_sync needs at least two stages");
  end

  logic [STAGES-1:0] chain_q;

  // Only the last stage is seen outside the chain
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], 1'b1};
    end
  end

  assign o_rst_n = chain_q[STAGES-1];
endmodule

// file: rsq_top.sv
// Reset sequencer: arbitrates external and watchdog reset, times the
// exit from reset, and selects the clock source for each serial port.
// Assumes the watchdog supplies a one-cycle timeout pulse; the reset
// source keeps the input low long enough for the logic to settle.
`timescale 1ns/1ps
module rsq_top
  import rsq_pkg::*;
#(
  parameter int WDOG_EXIT_CYC = RSQ_WDOG_EXIT_CYC,
  parameter int SYNC_STAGES   = RSQ_SYNC_STAGES
) (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_ext_reset_in_n,
  input  wire logic       i_wdog_timeout,
  input  wire logic       i_wdog_flag_clear,
  input  wire logic       i_uart_clk_sel,
  input  wire logic       i_hsuart_clk_sel,
  input  wire logic       i_cpu_clk_en,
  input  wire logic       i_alt_serial_clock_in,
  output logic            o_system_reset_out,
  output logic            o_core_reset,
  output rsq_cpu_ctl_type o_cpu_ctl,
  output logic            o_wdog_reset_cause_flag,
  output logic            o_uart_clk_en,
  output logic            o_hsuart_clk_en
);
  initial begin
    if (WDOG_EXIT_CYC < 2) $error("WDOG_EXIT_CYC too small");
    if (SYNC_STAGES < 2) $error("SYNC_STAGES below two");
    if (SYNC_STAGES > RSQ_OUT_HOLD_CYC) $error("SYNC_STAGES exceeds the reset out hold");
    if (SYNC_STAGES + 1 >= RSQ_BUS_START_CYC) $error("SYNC_STAGES passes the bus start");
    if (RSQ_BUS_START_CYC >= RSQ_FETCH_CYC) $error("bus start must precede fetch");
    if (RSQ_FETCH_CYC > 31) $error("fetch point beyond the exit counter");
  end

  localparam int WCW = $clog2(WDOG_EXIT_CYC + 1);

  // True once the exit count has reached the edge before a milestone
  function automatic logic rsq_exit_past(input rsq_state_type st,
                                         input logic [4:0]    cnt,
                                         input int            mark);
    return (st == RSQ_ST_EXIT) && (cnt >= 5'(mark - 1));
  endfunction

  // True only on the edge that reaches a milestone
  function automatic logic rsq_exit_at(input rsq_state_type st,
                                       input logic [4:0]    cnt,
                                       input int            mark);
    return (st == RSQ_ST_EXIT) && (cnt == 5'(mark - 1));
  endfunction

  // Serial clock source: alternate pin when selected, else processor tick
  function automatic logic rsq_pick_clk(input logic sel,
                                        input logic alt,
                                        input logic cpu);
    return sel ? alt : cpu;
  endfunction

  logic          ext_rst_n;
  logic          arst_n;
  rsq_state_type state_q;
  logic [4:0]    exit_cnt_q;
  logic [WCW-1:0] wdog_cnt_q;
  logic          from_wdog_q;

  // Either source resets at once, even while the clock is not yet running
  assign arst_n = i_ext_reset_in_n & ~i_sys_rst;

  rsq_sync #(
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (arst_n),
    .o_rst_n (ext_rst_n)
  );

  // Async reset clears sequencing state at once, mid-cycle
  always_ff @(posedge i_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= RSQ_ST_EXT;
    end else begin
      unique case (state_q)
        RSQ_ST_RUN: begin
          if (i_wdog_timeout) begin
            state_q <= RSQ_ST_WDOG;
          end
        end
        RSQ_ST_EXT: begin
          if (ext_rst_n) begin
            state_q <= RSQ_ST_EXIT;
          end
        end
        RSQ_ST_WDOG: begin
          if (wdog_cnt_q == WCW'(WDOG_EXIT_CYC - 1)) begin
            state_q <= RSQ_ST_EXIT;
          end
        end
        RSQ_ST_EXIT: begin
          if (rsq_exit_at(state_q, exit_cnt_q, RSQ_FETCH_CYC)) begin
            state_q <= RSQ_ST_RUN;
          end
        end
      endcase
    end
  end

  // Runs only in WDOG, so a stale count never shortens a later reset
  always_ff @(posedge i_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdog_cnt_q <= '0;
    end else if (state_q == RSQ_ST_WDOG) begin
      wdog_cnt_q <= wdog_cnt_q + WCW'(1);
    end else begin
      wdog_cnt_q <= '0;
    end
  end

  // Release at edge e0 shows at the synchronizer after e2 and moves the
  // state out of EXT at e3, where the count is loaded with 3. From then on
  // the count equals edges since release: bus at e5, fetch at e7.
  // A watchdog exit has no synchronizer, so its count starts at zero.
  always_ff @(posedge i_clk or negedge arst_n) begin
    if (!arst_n) begin
      exit_cnt_q <= RSQ_CNT_ZERO;
    end else if (state_q == RSQ_ST_EXIT) begin
      exit_cnt_q <= exit_cnt_q + 5'h01;
    end else if (state_q == RSQ_ST_EXT && ext_rst_n) begin
      exit_cnt_q <= 5'(SYNC_STAGES + 1);
    end else begin
      exit_cnt_q <= RSQ_CNT_ZERO;
    end
  end

  always_ff @(posedge i_clk or negedge arst_n) begin
    if (!arst_n) begin
      from_wdog_q <= 1'b0;
    end else if (state_q == RSQ_ST_WDOG) begin
      from_wdog_q <= 1'b1;
    end else if (state_q == RSQ_ST_RUN) begin
      from_wdog_q <= 1'b0;
    end
  end

  // Set only when a watchdog reset runs to its exit; an external reset
  // clears it through the async branch, and a set beats a clear
  always_ff @(posedge i_clk or negedge arst_n) begin
    if (!arst_n) begin
      o_wdog_reset_cause_flag <= 1'b0;
    end else if ((state_q == RSQ_ST_EXIT) && from_wdog_q) begin
      o_wdog_reset_cause_flag <= 1'b1;
    end else if (i_wdog_flag_clear) begin
      o_wdog_reset_cause_flag <= 1'b0;
    end
  end

  // High in every reset the synchronizer delay is the two-clock
  // hold, so it drops on the edge that leaves EXT
  always_ff @(posedge i_clk or negedge arst_n) begin
    if (!arst_n) begin
      o_system_reset_out <= 1'b1;
    end else begin
      o_system_reset_out <= ((state_q == RSQ_ST_EXT) && !ext_rst_n) ||
                            (state_q == RSQ_ST_WDOG);
    end
  end

  // Core held until first bus cycle point
  always_ff @(posedge i_clk or negedge arst_n) begin
    if (!arst_n) begin
      o_core_reset <= 1'b1;
    end else begin
      o_core_reset <= (state_q != RSQ_ST_RUN) &&
                      !rsq_exit_past(state_q, exit_cnt_q, RSQ_BUS_START_CYC);
    end
  end

  // Bus then fetch enables, restart vector fixed
  always_ff @(posedge i_clk or negedge arst_n) begin
    if (!arst_n) begin
      o_cpu_ctl <= '{bus_enable: 1'b0, fetch_enable: 1'b0, restart_addr: RSQ_RESTART_ADDR};
    end else begin
      o_cpu_ctl.restart_addr <= RSQ_RESTART_ADDR;
      o_cpu_ctl.bus_enable   <= (state_q == RSQ_ST_RUN) ||
                                rsq_exit_past(state_q, exit_cnt_q, RSQ_BUS_START_CYC);
      o_cpu_ctl.fetch_enable <= (state_q == RSQ_ST_RUN) ||
                                rsq_exit_at(state_q, exit_cnt_q, RSQ_FETCH_CYC);
    end
  end

  // Independent per-port source; alt pin sampled as a clock enable
  always_ff @(posedge i_clk or negedge arst_n) begin
    if (!arst_n) begin
      o_uart_clk_en <= 1'b0;
    end else begin
      o_uart_clk_en <= rsq_pick_clk(i_uart_clk_sel, i_alt_serial_clock_in, i_cpu_clk_en);
    end
  end

  // Own process, so one port's select never gates the other
  always_ff @(posedge i_clk or negedge arst_n) begin
    if (!arst_n) begin
      o_hsuart_clk_en <= 1'b0;
    end else begin
      o_hsuart_clk_en <= rsq_pick_clk(i_hsuart_clk_sel, i_alt_serial_clock_in, i_cpu_clk_en);
    end
  end
endmodule

// file: rsq_top_assertions.sv
// Port-level checker for rsq_top.
// Assumes one clock domain; bound to every rsq_top instance.
`timescale 1ns/1ps
module rsq_top_chk
  import rsq_pkg::*;
(
  input wire logic            i_clk,
  input wire logic            i_sys_rst,
  input wire logic            i_ext_reset_in_n,
  input wire logic            i_wdog_timeout,
  input wire logic            i_uart_clk_sel,
  input wire logic            i_hsuart_clk_sel,
  input wire logic            i_cpu_clk_en,
  input wire logic            i_alt_serial_clock_in,
  input wire logic            o_system_reset_out,
  input wire logic            o_core_reset,
  input wire rsq_cpu_ctl_type o_cpu_ctl,
  input wire logic            o_wdog_reset_cause_flag,
  input wire logic            o_uart_clk_en,
  input wire logic            o_hsuart_clk_en
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [1:0] sel_q;
  // Expected enables, one cycle behind the pins
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) sel_q <= 2'h0;
    else sel_q <= {i_hsuart_clk_sel ? i_alt_serial_clock_in : i_cpu_clk_en,
                   i_uart_clk_sel ? i_alt_serial_clock_in : i_cpu_clk_en};
  end
  a_ext_clears_all: assert property (!i_ext_reset_in_n |-> o_system_reset_out && o_core_reset
    && !o_cpu_ctl.bus_enable && !o_cpu_ctl.fetch_enable) else $error("reset not immediate");
  a_out_hold_two: assert property ($rose(i_ext_reset_in_n) |-> o_system_reset_out[*2]
    ##[1:3] !o_system_reset_out) else $error("reset out hold wrong");
  a_bus_start_time: assert property ($rose(i_ext_reset_in_n) |-> !o_cpu_ctl.bus_enable[*3]
    ##[1:4] o_cpu_ctl.bus_enable) else $error("bus start wrong");
  a_fetch_start_time: assert property ($rose(i_ext_reset_in_n) |-> !o_cpu_ctl.fetch_enable[*5]
    ##[1:5] o_cpu_ctl.fetch_enable) else $error("fetch start wrong");
  a_wdog_reset_out: assert property (i_wdog_timeout && o_cpu_ctl.fetch_enable && i_ext_reset_in_n
    |-> ##2 o_system_reset_out[*8]) else $error("watchdog reset out missing");
  a_ext_flag_clear: assert property (!i_ext_reset_in_n |-> !o_wdog_reset_cause_flag)
    else $error("cause flag set under external reset");
  a_restart_addr: assert property (o_cpu_ctl.bus_enable |-> o_cpu_ctl.restart_addr == RSQ_RESTART_ADDR)
    else $error("restart address wrong");
  a_clk_sel_pick: assert property (!o_core_reset && $past(o_core_reset) == 1'h0
    |-> {o_hsuart_clk_en, o_uart_clk_en} == sel_q) else $error("serial clock select wrong");
endmodule
bind rsq_top rsq_top_chk chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_ext_reset_in_n(i_ext_reset_in_n), .i_wdog_timeout(i_wdog_timeout),
  .i_uart_clk_sel(i_uart_clk_sel), .i_hsuart_clk_sel(i_hsuart_clk_sel),
  .i_cpu_clk_en(i_cpu_clk_en), .i_alt_serial_clock_in(i_alt_serial_clock_in),
  .o_system_reset_out(o_system_reset_out), .o_core_reset(o_core_reset), .o_cpu_ctl(o_cpu_ctl),
  .o_wdog_reset_cause_flag(o_wdog_reset_cause_flag), .o_uart_clk_en(o_uart_clk_en),
  .o_hsuart_clk_en(o_hsuart_clk_en));

// file: rsq_partner.sv
// External reset source and a peripheral counting system resets.
// Assumes the bench calls hold_reset on a clock edge.
`timescale 1ns/1ps
module rsq_partner (
  input  wire logic i_clk,
  input  wire logic i_system_reset_out,
  output logic      o_ext_reset_in_n
);
  int resets_seen = 0;
  initial o_ext_reset_in_n = 1'h1;
  // Hold is in cycles; a real source must keep it for a millisecond
  task automatic hold_reset(input int cyc);
    o_ext_reset_in_n <= 1'h0;
    repeat ((cyc < rsq_pkg::RSQ_STABLE_CYC) ? rsq_pkg::RSQ_STABLE_CYC : cyc) @(posedge i_clk);
    o_ext_reset_in_n <= 1'h1;
  endtask
  always @(posedge i_system_reset_out) resets_seen++;
endmodule

// file: testbench.sv
// Self-checking bench for rsq_top with the reset-source model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module testbench;
  import rsq_pkg::*;
  localparam int W = 16;
  logic i_clk, i_sys_rst, ext_n, wdog, fclr, usel, hsel, cpu_en, alt;
  logic sys_out, core_rst, flag, uen, hen;
  logic [3:0] r;
  logic [1:0] exp_q;
  rsq_cpu_ctl_type ctl;
  int num_errors = 0, check_count = 0, seed, t_o, t_b, t_f, t_c, base;
  rsq_top #(.WDOG_EXIT_CYC(W)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_ext_reset_in_n(ext_n), .i_wdog_timeout(wdog), .i_wdog_flag_clear(fclr),
    .i_uart_clk_sel(usel), .i_hsuart_clk_sel(hsel), .i_cpu_clk_en(cpu_en),
    .i_alt_serial_clock_in(alt), .o_system_reset_out(sys_out), .o_core_reset(core_rst),
    .o_cpu_ctl(ctl), .o_wdog_reset_cause_flag(flag), .o_uart_clk_en(uen),
    .o_hsuart_clk_en(hen));
  rsq_partner src (.i_clk(i_clk), .i_system_reset_out(sys_out), .o_ext_reset_in_n(ext_n));
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (exp !== got) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  function automatic logic pick(input logic sel, input logic a, input logic c);
    return sel ? a : c;
  endfunction
  // Edges after the last drive until each milestone shows
  task automatic measure();
    t_o = 0;
    t_b = 0;
    t_f = 0;
    t_c = 0;
    for (int i = 1; i <= 40; i++) begin
      @(posedge i_clk);
      #1;
      if (t_o == 0 && sys_out === 1'h0) t_o = i;
      if (t_b == 0 && ctl.bus_enable === 1'h1) t_b = i;
      if (t_f == 0 && ctl.fetch_enable === 1'h1) t_f = i;
      if (t_c == 0 && core_rst === 1'h0) t_c = i;
    end
  endtask
  task automatic ext_cycle(input int hold);
    @(posedge i_clk) src.hold_reset(hold);
    measure();
    // Output register adds one edge to the two-clock hold
    compare("out drop", RSQ_OUT_HOLD_CYC + 1, t_o);
    compare("bus start", RSQ_BUS_START_CYC, t_b);
    compare("core release", RSQ_BUS_START_CYC, t_c);
    compare("fetch start", RSQ_FETCH_CYC, t_f);
    compare("restart addr", RSQ_RESTART_ADDR, ctl.restart_addr);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    #50000;
    num_errors++;
    give_verdict();
  end
  initial begin
    seed = 32'h8b83e372;
    {i_sys_rst, wdog, fclr, usel, hsel, cpu_en, alt} = 7'h40;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    repeat (10) @(posedge i_clk);
    base = src.resets_seen;
    for (int k = 0; k < 3; k++) ext_cycle(4 + ($random(seed) & 7));
    $display("test external reset done");
    @(posedge i_clk) wdog <= 1'h1;
    @(posedge i_clk) wdog <= 1'h0;
    @(posedge i_clk) #1 compare("wdog out", 1'h1, sys_out);
    measure();
    compare("wdog exit", 1'h1, t_o >= W - 1 && t_o <= W + 1);
    compare("cause flag", 1'h1, flag);
    @(posedge i_clk) fclr <= 1'h1;
    @(posedge i_clk) fclr <= 1'h0;
    #1 compare("flag clear", 1'h0, flag);
    $display("test watchdog reset done");
    @(posedge i_clk) wdog <= 1'h1;
    @(posedge i_clk) wdog <= 1'h0;
    repeat (4) @(posedge i_clk);
    ext_cycle(6);
    compare("override flag", 1'h0, flag);
    compare("resets seen", 32'h5, src.resets_seen - base);
    $display("test override done");
    for (int k = 0; k < 64; k++) begin
      @(posedge i_clk);
      r = 4'($random(seed));
      {usel, hsel, cpu_en, alt} <= r;
      #1 if (k > 0) compare("clk enables", exp_q, {hen, uen});
      exp_q = {pick(r[2], r[0], r[1]), pick(r[3], r[0], r[1])};
    end
    $display("test clock select done");
    give_verdict();
  end
endmodule
